// ==== logic/aoc_defs.vh ====
// Function
// - bit 14 of reg 1 merges two serial pairs onto one pair
// - bit 5 of reg 1 turns the whole serial output off
// - bit 0 of reg 1 puts the converter in full power-down
// - bits 15..13 of reg 2 select the frame-line test pattern
// - bit 12 of reg 2 bypasses digital features for low latency
// - bit 11 of reg 2 averages two channels
// - bit 10 of reg 2 drives pseudo-random bits on the frame line
// - bits 9..7 of reg 2 select the data-line test pattern
// - bit 6 of reg 2 enables the global pseudo-random pattern
// - offset correction starts a programmed sample delay after trigger
// - pattern codes: normal,sync,alt,custom,ones,toggle,zeros,ramp
// - delay bits 7..6 come from bits 10..9 of reg 3
// - start source selects trigger pin or manual start bit
`ifndef AOC_DEFS_VH
`define AOC_DEFS_VH
// ----------------------------------------
// register indices
// ----------------------------------------
`define AOC_REG_OUTPWR   8'h01
`define AOC_REG_PATLAT   8'h02
`define AOC_REG_SERDLY   8'h03
`define AOC_REG_OFFCTL   8'h04
`define AOC_RESET_VAL    16'h0000
// ----------------------------------------
// field positions
// ----------------------------------------
`define AOC_DUAL_RATE_BIT    14
`define AOC_OUT_OFF_BIT      5
`define AOC_PDN_BIT          0
`define AOC_FPAT_HI          15
`define AOC_FPAT_LO          13
`define AOC_LOWLAT_BIT       12
`define AOC_AVG_BIT          11
`define AOC_FPRBS_BIT        10
`define AOC_DPAT_HI          9
`define AOC_DPAT_LO          7
`define AOC_GPRBS_BIT        6
`define AOC_DLY_LO_HI        5
`define AOC_DLY_HI_HI        10
`define AOC_DLY_HI_LO        9
`define AOC_START_SRC_BIT    14
`define AOC_START_MAN_BIT    13
// ----------------------------------------
// pattern codes
// ----------------------------------------
`define AOC_PAT_NORMAL   3'h0
`define AOC_PAT_SYNC     3'h1
`define AOC_PAT_ALT      3'h2
`define AOC_PAT_CUSTOM   3'h3
`define AOC_PAT_ONES     3'h4
`define AOC_PAT_TOGGLE   3'h5
`define AOC_PAT_ZEROS    3'h6
`define AOC_PAT_RAMP     3'h7
`endif

// ==== logic/aoc_regs.v ====
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
`include "aoc_defs.vh"
module aoc_regs
(
  input  wire        mclk_i,
  input  wire        rst_b_i,
  input  wire [7:0]  addr_i,
  input  wire [15:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  input  wire        sample_tick_i,
  input  wire        transmit_trigger_in_i,
  output reg  [15:0] rdata_o,
  output reg         dual_pair_rate_o,
  output reg         serial_output_off_o,
  output reg         full_powerdown_o,
  output reg         low_latency_o,
  output reg         pair_averaging_o,
  output reg         frame_line_prbs_o,
  output reg         global_prbs_o,
  output reg  [7:0]  frame_line_pattern_o,
  output reg  [7:0]  data_line_pattern_o,
  output reg         offset_corr_start_o,
  output reg         offset_corr_busy_o
);
  // ----------------------------------------
  // register storage
  // ----------------------------------------
  reg [15:0] outpwr_r;
  reg [15:0] patlat_r;
  reg [15:0] serdly_r;
  reg [15:0] offctl_r;
  reg [2:0]  trig_sync_r;
  reg [7:0]  dly_cnt_r;
  reg        armed_r;
  wire       trig_rise;
  wire       man_start;
  wire       start_req;
  wire [7:0] dly_val;
  wire [2:0] fpat;
  wire [2:0] dpat;
  // leaves reserved-bit values to the host; they are stored as written
  always @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      outpwr_r <= `AOC_RESET_VAL;
      patlat_r <= `AOC_RESET_VAL;
      serdly_r <= `AOC_RESET_VAL;
      offctl_r <= `AOC_RESET_VAL;
    end
    else
    begin
      // manual start bit self-clears after one cycle, even when another
      // register is written then, so it can never start twice
      if (offctl_r[`AOC_START_MAN_BIT])
        offctl_r[`AOC_START_MAN_BIT] <= 1'b0;
      if (wr_i)
      begin
        case (addr_i)
          `AOC_REG_OUTPWR: outpwr_r <= wdata_i;
          `AOC_REG_PATLAT: patlat_r <= wdata_i;
          `AOC_REG_SERDLY: serdly_r <= wdata_i;
          `AOC_REG_OFFCTL: offctl_r <= wdata_i;
          default:         outpwr_r <= outpwr_r;
        endcase
      end
    end
  end

  // ----------------------------------------
  // read port, one cycle latency
  // ----------------------------------------
  always @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rdata_o <= 16'h0000;
    else if (rd_i)
    begin
      case (addr_i)
        `AOC_REG_OUTPWR: rdata_o <= outpwr_r;
        `AOC_REG_PATLAT: rdata_o <= patlat_r;
        `AOC_REG_SERDLY: rdata_o <= serdly_r;
        `AOC_REG_OFFCTL: rdata_o <= {offctl_r[15:1], offset_corr_busy_o};
        default:         rdata_o <= 16'h0000;
      endcase
    end
    else
      rdata_o <= 16'h0000;
  end

  // ----------------------------------------
  // trigger pin sampling
  // ----------------------------------------
  always @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      trig_sync_r <= 3'h0;
    else
      trig_sync_r <= {trig_sync_r[1:0], transmit_trigger_in_i};
  end
  // stage 0 is read only by stage 1
  assign trig_rise = (trig_sync_r[1] == trig_sync_r[2]) ? 1'b0 :
                     trig_sync_r[1];

  assign man_start = offctl_r[`AOC_START_MAN_BIT];
  assign start_req = offctl_r[`AOC_START_SRC_BIT] ? trig_rise
                                                 : man_start;
  assign dly_val   = {serdly_r[`AOC_DLY_HI_HI:`AOC_DLY_HI_LO],
                      patlat_r[`AOC_DLY_LO_HI:0]};
  assign fpat      = patlat_r[`AOC_FPAT_HI:`AOC_FPAT_LO];
  assign dpat      = patlat_r[`AOC_DPAT_HI:`AOC_DPAT_LO];

  // ----------------------------------------
  // offset-correction delay counter
  // ----------------------------------------
  // counts sample periods; zero delay starts on the first sample tick
  always @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dly_cnt_r           <= 8'h00;
      armed_r             <= 1'b0;
      offset_corr_start_o <= 1'b0;
    end
    else
    begin
      offset_corr_start_o <= 1'b0;
      if (start_req)
      begin
        dly_cnt_r <= dly_val;
        armed_r   <= 1'b1;
      end
      else if (armed_r && sample_tick_i)
      begin
        if (dly_cnt_r == 8'h00)
        begin
          armed_r             <= 1'b0;
          offset_corr_start_o <= 1'b1;
        end
        else
          dly_cnt_r <= dly_cnt_r - 8'h01;
      end
    end
  end

  // ----------------------------------------
  // decoded controls
  // ----------------------------------------
  always @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dual_pair_rate_o     <= 1'b0;
      serial_output_off_o  <= 1'b0;
      full_powerdown_o     <= 1'b0;
      low_latency_o        <= 1'b0;
      pair_averaging_o     <= 1'b0;
      frame_line_prbs_o    <= 1'b0;
      global_prbs_o        <= 1'b0;
      frame_line_pattern_o <= 8'h01;
      data_line_pattern_o  <= 8'h01;
      offset_corr_busy_o   <= 1'b0;
    end
    else
    begin
      dual_pair_rate_o     <= outpwr_r[`AOC_DUAL_RATE_BIT];
      serial_output_off_o  <= outpwr_r[`AOC_OUT_OFF_BIT];
      full_powerdown_o     <= outpwr_r[`AOC_PDN_BIT];
      low_latency_o        <= patlat_r[`AOC_LOWLAT_BIT];
      pair_averaging_o     <= patlat_r[`AOC_AVG_BIT];
      frame_line_prbs_o    <= patlat_r[`AOC_FPRBS_BIT];
      global_prbs_o        <= patlat_r[`AOC_GPRBS_BIT];
      // one-hot pattern decode, bit n set for code n
      frame_line_pattern_o <= 8'h01 << fpat;
      data_line_pattern_o  <= 8'h01 << dpat;
      offset_corr_busy_o   <= armed_r;
    end
  end
endmodule // aoc_regs

// ==== testbench/aoc_far_end.sv ====
`timescale 1ns/10ps
module aoc_far_end (
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  input  wire logic fire_i,
  output logic      sample_tick_o,
  output logic      trig_o
);
  logic [1:0] cnt_r;
  always @(posedge mclk_i or negedge rst_b_i)
    if (!rst_b_i) cnt_r <= 2'h0;
    else cnt_r <= cnt_r + 2'h1;
  assign sample_tick_o = (cnt_r == 2'h3);
  initial trig_o = 1'b0;
  // pin pulse lasts one link period, rising 3 ns after an mclk rising edge
  always @(posedge fire_i)
  begin
    #3 trig_o = 1'b1;
    #160 trig_o = 1'b0;
  end
endmodule // aoc_far_end

// ==== testbench/aoc_regs_assertions.sv ====
`timescale 1ns/10ps
module aoc_regs_chk (
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  input wire logic [7:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic        sample_tick_i,
  input wire logic [15:0] rdata_o,
  input wire logic        dual_pair_rate_o,
  input wire logic        serial_output_off_o,
  input wire logic        full_powerdown_o,
  input wire logic        low_latency_o,
  input wire logic        pair_averaging_o,
  input wire logic        frame_line_prbs_o,
  input wire logic        global_prbs_o,
  input wire logic [7:0]  frame_line_pattern_o,
  input wire logic [7:0]  data_line_pattern_o,
  input wire logic        offset_corr_start_o,
  input wire logic        offset_corr_busy_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  a_reg1_outs:
    assert property (wr_i && addr_i == 8'h01 |-> ##2 {dual_pair_rate_o,
      serial_output_off_o, full_powerdown_o} == {$past(wdata_i[14], 2),
      $past(wdata_i[5], 2), $past(wdata_i[0], 2)}) else $error("reg1 out");
  a_reg2_flags:
    assert property (wr_i && addr_i == 8'h02 |-> ##2 {low_latency_o,
      pair_averaging_o, frame_line_prbs_o, global_prbs_o} ==
      {$past(wdata_i[12:10], 2), $past(wdata_i[6], 2)}) else $error("flags");
  a_frame_pat:
    assert property (wr_i && addr_i == 8'h02 |-> ##2 frame_line_pattern_o ==
      8'h01 << $past(wdata_i[15:13], 2)) else $error("frame pattern");
  a_data_pat:
    assert property (wr_i && addr_i == 8'h02 |-> ##2 data_line_pattern_o ==
      8'h01 << $past(wdata_i[9:7], 2)) else $error("data pattern");
  a_pat_onehot:
    assert property ($onehot(frame_line_pattern_o) &&
      $onehot(data_line_pattern_o)) else $error("pattern not one-hot");
  a_unmapped_rd:
    assert property (rd_i && addr_i > 8'h04 |=> rdata_o == 16'h0000)
      else $error("unmapped read");
  a_start_tick:
    assert property (offset_corr_start_o |-> $past(sample_tick_i) &&
      offset_corr_busy_o) else $error("start without tick");
  a_start_pulse:
    assert property (offset_corr_start_o |=> !offset_corr_start_o)
      else $error("start too long");
endmodule // aoc_regs_chk

// ==== testbench/test_aoc_regs.sv ====
`timescale 1ns/10ps
module test_aoc_regs;
  logic        mclk_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0, fire = 0;
  logic [7:0]  addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000;
  wire  [15:0] rdata_o;
  wire  [7:0]  fpat, dpat;
  wire         tick, trig, rate, off, pdn, lowl, avg, fprbs, gprbs;
  wire         start, busy;
  int          miscompares = 0, num_checks = 0, n;
  logic [2:0]  c, p;
  always #4 mclk_i = ~mclk_i;
  aoc_regs aoc_regs_inst (.mclk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .sample_tick_i(tick), .transmit_trigger_in_i(trig), .rdata_o,
    .dual_pair_rate_o(rate), .serial_output_off_o(off),
    .full_powerdown_o(pdn), .low_latency_o(lowl), .pair_averaging_o(avg),
    .frame_line_prbs_o(fprbs), .global_prbs_o(gprbs),
    .frame_line_pattern_o(fpat), .data_line_pattern_o(dpat),
    .offset_corr_start_o(start), .offset_corr_busy_o(busy));
  aoc_far_end aoc_far_end_inst (.mclk_i, .rst_b_i, .fire_i(fire),
    .sample_tick_o(tick), .trig_o(trig));
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 chk("read data", rdata_o, e);
    @(posedge mclk_i);
  endtask
  // ticks consumed while pending, the last one included
  task wait_start(input logic [15:0] e);
    int i;
    logic t_prev;
    n = 0;
    #1 t_prev = tick;
    for (i = 0; i < 3000; i++)
    begin
      @(posedge mclk_i);
      #1 if (busy === 1'b1 && t_prev === 1'b1) n++;
      t_prev = tick;
      if (start === 1'b1) break;
    end
    if (i == 3000) begin miscompares++; complete_run; end
    chk("delay ticks", n[15:0], e);
    @(posedge mclk_i);
  endtask
  initial
  begin
    repeat (10) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    #1 chk("reset patterns", {fpat, dpat}, 16'h0101);
    chk("reset flags", {7'h00, rate, off, pdn, lowl, avg, fprbs, gprbs,
      start, busy}, 16'h0000);
    @(posedge mclk_i);
    rd(8'h02, 16'h0000);
    wr(8'h01, 16'h4035);
    wr(8'h09, 16'hFFFF);
    rd(8'h01, 16'h4035);
    rd(8'h09, 16'h0000);
    chk("reg1 set", {13'h0000, rate, off, pdn}, 16'h0007);
    wr(8'h01, 16'h0014);
    for (int k = 0; k < 8; k++)
    begin
      c = k[2:0];
      p = {1'b0, c == 3'h3 || c == 3'h7, c == 3'h0 || c == 3'h4};
      wr(8'h02, {c, c[2:1], p[1], 3'h7 - c, p[0], 6'h00});
      repeat (2) @(posedge mclk_i);
      #1 chk("frame pattern", {8'h00, fpat}, 16'h0001 << c);
      chk("data pattern", {8'h00, dpat}, 16'h0001 << (3'h7 - c));
      chk("flags", {12'h000, lowl, avg, fprbs, gprbs},
        {12'h000, c[2:1], p[1:0]});
      @(posedge mclk_i);
    end
    chk("reg1 clear", {13'h0000, rate, off, pdn}, 16'h0000);
    wr(8'h03, 16'h0200);
    wr(8'h02, 16'h0003);
    wr(8'h04, 16'h2000);
    wait_start(16'd68);
    wr(8'h03, 16'h0000);
    wr(8'h02, 16'h0005);
    wr(8'h04, 16'h4000);
    fire <= 1'b1;
    @(posedge mclk_i);
    fire <= 1'b0;
    wait_start(16'd6);
    complete_run;
  end
endmodule // test_aoc_regs
bind aoc_regs aoc_regs_chk aoc_regs_chk_inst (.mclk_i(mclk_i),
  .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .sample_tick_i(sample_tick_i), .rdata_o(rdata_o),
  .dual_pair_rate_o(dual_pair_rate_o),
  .serial_output_off_o(serial_output_off_o),
  .full_powerdown_o(full_powerdown_o), .low_latency_o(low_latency_o),
  .pair_averaging_o(pair_averaging_o),
  .frame_line_prbs_o(frame_line_prbs_o), .global_prbs_o(global_prbs_o),
  .frame_line_pattern_o(frame_line_pattern_o),
  .data_line_pattern_o(data_line_pattern_o),
  .offset_corr_start_o(offset_corr_start_o),
  .offset_corr_busy_o(offset_corr_busy_o));
